// ---- inc/rwp_pkg.sv ----
// constants and types for the stored-waveform playlist player
package rwp_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int SMP_W  = 12;
	localparam int NUM_WAVES = 16;
	localparam int IDX_W  = 4;
	localparam int CNT_W  = 5;
	localparam int REP_W  = 8;
	localparam int RAM_AW = 13;
	localparam int RAM_DEPTH = 8192;
	localparam int CAP_W  = 14;
	localparam int DIV_W  = 13;

	// host window onto the waveform memory
	localparam logic [ADDR_W-1:0] RAM_BASE = 16'h2000;
	localparam logic [ADDR_W-1:0] RAM_TOP  = 16'h3FFF;
	localparam logic [2:0]        RAM_PAGE = 3'h1;
	// total words shared between streaming queue and stored waveforms
	localparam logic [CAP_W-1:0]  SHARED_DEPTH = 14'h2400;

	// register offsets
	localparam logic [ADDR_W-1:0] REG_CTRL     = 16'h0000;
	localparam logic [ADDR_W-1:0] REG_RATE     = 16'h0001;
	localparam logic [ADDR_W-1:0] REG_NSTORED  = 16'h0002;
	localparam logic [ADDR_W-1:0] REG_NPLAY    = 16'h0003;
	localparam logic [ADDR_W-1:0] REG_RD_ADDR  = 16'h0004;
	localparam logic [ADDR_W-1:0] REG_RD_DATA  = 16'h0005;
	localparam logic [ADDR_W-1:0] REG_CAPACITY = 16'h0006;
	localparam logic [ADDR_W-1:0] REG_STATUS   = 16'h0007;
	localparam logic [11:0]       GRP_END      = 12'h001;
	localparam logic [11:0]       GRP_SEL      = 12'h002;
	localparam logic [11:0]       GRP_REP      = 12'h003;

	// bit positions
	localparam int CTRL_PLAY_BIT  = 0;
	localparam int STAT_INV_BIT   = 0;
	localparam int STAT_EMPTY_BIT = 1;
	localparam int STAT_BUSY_BIT  = 2;
	localparam int STAT_PEND_BIT  = 3;

	// reset values
	localparam logic [REP_W-1:0] REPEAT_RST = 8'h01;
	localparam logic [1:0]       RATE_RST   = 2'h1;

	// sample rates
	localparam logic [1:0] RATE_8K  = 2'h0;
	localparam logic [1:0] RATE_32K = 2'h1;
	localparam logic [1:0] RATE_48K = 2'h2;
	localparam int CLK_HZ      = 40000000;
	localparam int RATE_HZ_8K  = 8000;
	localparam int RATE_HZ_32K = 32000;
	localparam int RATE_HZ_48K = 48000;
	localparam int DIV_8K_DEF  = CLK_HZ / RATE_HZ_8K;
	localparam logic [DIV_W-1:0] DIV_32K = DIV_W'(CLK_HZ / RATE_HZ_32K);
	localparam logic [DIV_W-1:0] DIV_48K = DIV_W'(CLK_HZ / RATE_HZ_48K);

	// compression: code * 0.875 + 508, full code 4095
	localparam int                COMP_MUL   = 7;
	localparam int                COMP_SHIFT = 3;
	localparam logic [SMP_W-1:0]  COMP_OFS   = 12'h1FC;
	localparam logic [SMP_W-1:0]  FULL_CODE  = 12'hFFF;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_LOAD = 3'b010,
		ST_PLAY = 3'b100
	} rwp_state_t;
endpackage

// ---- rtl/rwp_compander.sv ----
// sample code compression ahead of the dac
`timescale 1ns/1ps
`default_nettype none
module rwp_compander
	import rwp_pkg::*;
(
	// raw and compressed code
	input  wire logic [rwp_pkg::SMP_W-1:0] code,
	output logic      [rwp_pkg::SMP_W-1:0] comp
);
	logic [SMP_W+2:0] prod;

	// 0.875 taken as 7/8; worst case 4095 maps to 4091, so no clamp needed
	always_comb begin
		prod = (SMP_W+3)'(code) * (SMP_W+3)'(COMP_MUL);
		comp = SMP_W'(prod >> COMP_SHIFT) + COMP_OFS;
	end
endmodule // rwp_compander
`default_nettype wire

// ---- rtl/rwp_player.sv ----
// stored-waveform memory, playlist registers and playback sequencer
`timescale 1ns/1ps
`default_nettype none
module rwp_player
	import rwp_pkg::*;
#(
	parameter int DIV_8K = rwp_pkg::DIV_8K_DEF
)(
	// clock and reset
	input  wire logic                       ref_clk,
	input  wire logic                       rst_n,
	// register port
	input  wire logic [rwp_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [rwp_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	output logic      [rwp_pkg::DATA_W-1:0] reg_rdata,
	// streaming path arbitration
	input  wire logic                       stream_active,
	output logic                            stream_grant,
	// dac side
	output logic      [rwp_pkg::SMP_W-1:0]  dac_code,
	output logic                            dac_strobe,
	output logic                            play_busy
);
	import rwp_pkg::*;

	logic [SMP_W-1:0]  mem [RAM_DEPTH];
	logic [ADDR_W-1:0] waveform_end_address [NUM_WAVES];
	logic [IDX_W-1:0]  playlist_entry_select [NUM_WAVES];
	logic [REP_W-1:0]  repeat_count [NUM_WAVES];
	logic              play;
	logic [1:0]        sample_rate_select;
	logic [CNT_W-1:0]  num_stored;
	logic [CNT_W-1:0]  num_play;
	logic [ADDR_W-1:0] rd_ptr;
	logic              fault_inv;
	logic              fault_empty;
	logic              pending;
	rwp_state_t        state;
	logic [CNT_W-1:0]  pos;
	logic [ADDR_W-1:0] cur_addr;
	logic [ADDR_W-1:0] wave_start;
	logic [ADDR_W-1:0] wave_end;
	logic [REP_W-1:0]  rep_left;
	logic              rep_inf;
	logic [DIV_W-1:0]  div_cnt;
	logic              tick;
	logic              wr_hit_end, wr_hit_sel, wr_hit_rep;
	logic              start, bad_order, bad_len, bad_empty, finish, clr_play;
	logic [IDX_W-1:0]  cur_sel;
	logic [ADDR_W-1:0] next_start;
	logic [CAP_W-1:0]  capacity;
	logic [ADDR_W-1:0] last_end;
	logic [SMP_W-1:0]  raw_code, comp_code;
	logic [DATA_W-1:0] next_rdata;
	function automatic logic in_ram(input logic [ADDR_W-1:0] a);
		return a[ADDR_W-1:RAM_AW] == RAM_PAGE;
	endfunction

	function automatic logic [DIV_W-1:0] rate_div(input logic [1:0] sel);
		case (sel)
			RATE_8K:  return DIV_W'(DIV_8K);
			RATE_48K: return DIV_48K;
			default:  return DIV_32K;
		endcase
	endfunction
	assign wr_hit_end = reg_wr && reg_addr[ADDR_W-1:IDX_W] == GRP_END;
	assign wr_hit_sel = reg_wr && reg_addr[ADDR_W-1:IDX_W] == GRP_SEL;
	assign wr_hit_rep = reg_wr && reg_addr[ADDR_W-1:IDX_W] == GRP_REP;

	// host writes into waveform memory; no reset, contents are data
	always_ff @(posedge ref_clk) begin
		if (reg_wr && in_ram(reg_addr)) begin
			mem[reg_addr[RAM_AW-1:0]] <= reg_wdata[SMP_W-1:0];
		end
	end

	// playlist and waveform table
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_WAVES; i++) begin
				waveform_end_address[i]  <= RAM_BASE;
				playlist_entry_select[i] <= '0;
				repeat_count[i]          <= REPEAT_RST;
			end
		end else begin
			if (wr_hit_end) begin
				waveform_end_address[reg_addr[IDX_W-1:0]] <= reg_wdata;
			end
			if (wr_hit_sel) begin
				playlist_entry_select[reg_addr[IDX_W-1:0]] <= reg_wdata[IDX_W-1:0];
			end
			if (wr_hit_rep) begin
				repeat_count[reg_addr[IDX_W-1:0]] <= reg_wdata[REP_W-1:0];
			end
		end
	end

	// scalar configuration
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sample_rate_select <= RATE_RST;
			num_stored         <= '0;
			num_play           <= '0;
		end else if (reg_wr) begin
			case (reg_addr)
				REG_RATE:    sample_rate_select <= reg_wdata[1:0];
				REG_NSTORED: num_stored <= reg_wdata[CNT_W-1:0];
				REG_NPLAY:   num_play <= reg_wdata[CNT_W-1:0];
				default: begin
				end
			endcase
		end
	end

	// host write of 1 wins over a same-cycle self clear, so a fresh request is kept
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			play <= 1'b0;
		end else if (reg_wr && reg_addr == REG_CTRL) begin
			play <= reg_wdata[CTRL_PLAY_BIT];
		end else if (clr_play) begin
			play <= 1'b0;
		end
	end

	// read pointer with burst advance
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rd_ptr <= RAM_BASE;
		end else if (reg_wr && reg_addr == REG_RD_ADDR) begin
			rd_ptr <= reg_wdata;
		end else if (reg_rd && reg_addr == REG_RD_DATA) begin
			rd_ptr <= rd_ptr + ADDR_W'(1);
		end
	end

	// sticky faults, write 1 to clear, a new fault wins over the clear
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			fault_inv   <= 1'b0;
			fault_empty <= 1'b0;
		end else begin
			if (start && (bad_len || bad_order)) begin
				fault_inv <= 1'b1;
			end else if (reg_wr && reg_addr == REG_STATUS && reg_wdata[STAT_INV_BIT]) begin
				fault_inv <= 1'b0;
			end
			if (start && bad_empty) begin
				fault_empty <= 1'b1;
			end else if (reg_wr && reg_addr == REG_STATUS && reg_wdata[STAT_EMPTY_BIT]) begin
				fault_empty <= 1'b0;
			end
		end
	end

	// start checks
	always_comb begin
		bad_order = 1'b0;
		for (int i = 1; i < NUM_WAVES; i++) begin
			if (CNT_W'(i) < num_stored && waveform_end_address[i] <= waveform_end_address[i-1]) begin
				bad_order = 1'b1;
			end
		end
		bad_len   = num_play == '0;
		bad_empty = num_stored == '0;
	end

	// a play request waits while the streaming path owns the dac
	assign pending      = play && state == ST_IDLE && stream_active;
	assign start        = play && state == ST_IDLE && !stream_active;
	assign stream_grant = state == ST_IDLE && !play;
	assign play_busy    = state != ST_IDLE;

	assign cur_sel    = playlist_entry_select[pos[IDX_W-1:0]];
	assign next_start = (cur_sel == '0) ? RAM_BASE
		: waveform_end_address[cur_sel - IDX_W'(1)] + ADDR_W'(1);

	assign finish   = state == ST_PLAY && play && tick && cur_addr == wave_end
		&& !rep_inf && rep_left <= REP_W'(1) && pos + CNT_W'(1) >= num_play;
	assign clr_play = (start && (bad_len || bad_order || bad_empty)) || finish;

	// playback sequencer
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state      <= ST_IDLE;
			pos        <= '0;
			cur_addr   <= RAM_BASE;
			wave_start <= RAM_BASE;
			wave_end   <= RAM_BASE;
			rep_left   <= '0;
			rep_inf    <= 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					pos <= '0;
					if (start && !(bad_len || bad_order || bad_empty)) begin
						state <= ST_LOAD;
					end
				end
				ST_LOAD: begin
					if (!play) begin
						state <= ST_IDLE;
					end else begin
						cur_addr   <= next_start;
						wave_start <= next_start;
						wave_end   <= waveform_end_address[cur_sel];
						rep_left   <= repeat_count[pos[IDX_W-1:0]];
						rep_inf    <= repeat_count[pos[IDX_W-1:0]] == '0;
						state      <= ST_PLAY;
					end
				end
				ST_PLAY: begin
					if (!play) begin
						state <= ST_IDLE;
					end else if (tick) begin
						if (cur_addr != wave_end) begin
							cur_addr <= cur_addr + ADDR_W'(1);
						end else if (rep_inf || rep_left > REP_W'(1)) begin
							cur_addr <= wave_start;
							if (!rep_inf) begin
								rep_left <= rep_left - REP_W'(1);
							end
						end else if (pos + CNT_W'(1) >= num_play) begin
							state <= ST_IDLE;
						end else begin
							pos   <= pos + CNT_W'(1);
							state <= ST_LOAD;
						end
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// sample clock divider, restarts with each entry
	always_ff @(posedge ref_clk) begin
		if (!rst_n || state != ST_PLAY) begin
			div_cnt <= '0;
		end else if (tick) begin
			div_cnt <= '0;
		end else begin
			div_cnt <= div_cnt + DIV_W'(1);
		end
	end
	assign tick = state == ST_PLAY && div_cnt == rate_div(sample_rate_select) - DIV_W'(1);
	// addresses outside the window read as zero
	assign raw_code = in_ram(cur_addr) ? mem[cur_addr[RAM_AW-1:0]] : '0;

	rwp_compander u_comp (
		.code (raw_code),
		.comp (comp_code)
	);

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			dac_code   <= '0;
			dac_strobe <= 1'b0;
		end else begin
			dac_strobe <= state == ST_PLAY && play && tick;
			if (state == ST_PLAY && play && tick) begin
				dac_code <= comp_code;
			end
		end
	end

	// streaming capacity
	always_comb begin
		last_end = waveform_end_address[IDX_W'(num_stored - CNT_W'(1))];
		if (num_stored == '0) begin
			capacity = SHARED_DEPTH;
		end else begin
			capacity = SHARED_DEPTH - CAP_W'(last_end - RAM_BASE + ADDR_W'(1));
		end
	end

	// register read mux
	always_comb begin
		next_rdata = '0;
		case (reg_addr[ADDR_W-1:IDX_W])
			GRP_END: next_rdata = waveform_end_address[reg_addr[IDX_W-1:0]];
			GRP_SEL: next_rdata = DATA_W'(playlist_entry_select[reg_addr[IDX_W-1:0]]);
			GRP_REP: next_rdata = DATA_W'(repeat_count[reg_addr[IDX_W-1:0]]);
			default: begin
				case (reg_addr)
					REG_CTRL:     next_rdata = DATA_W'(play);
					REG_RATE:     next_rdata = DATA_W'(sample_rate_select);
					REG_NSTORED:  next_rdata = DATA_W'(num_stored);
					REG_NPLAY:    next_rdata = DATA_W'(num_play);
					REG_RD_ADDR:  next_rdata = rd_ptr;
					REG_RD_DATA:  next_rdata = in_ram(rd_ptr) ? DATA_W'(mem[rd_ptr[RAM_AW-1:0]]) : '0;
					REG_CAPACITY: next_rdata = DATA_W'(capacity);
					REG_STATUS: begin
						next_rdata[STAT_INV_BIT]   = fault_inv;
						next_rdata[STAT_EMPTY_BIT] = fault_empty;
						next_rdata[STAT_BUSY_BIT]  = play_busy;
						next_rdata[STAT_PEND_BIT]  = pending;
					end
					default: next_rdata = '0;
				endcase
			end
		endcase
	end

	// data stands only in the cycle after the read strobe
	always_ff @(posedge ref_clk) begin
		if (!rst_n || !reg_rd) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= next_rdata;
		end
	end

	stop_on_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(state == ST_PLAY && !play) |=> (state == ST_IDLE && !dac_strobe))
		else $error("playback did not stop after play cleared");
	empty_fault_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(start && num_stored == '0) |=> (fault_empty && state == ST_IDLE && !play))
		else $error("empty memory start not faulted");
	zero_length_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(start && num_play == '0) |=> (fault_inv && state == ST_IDLE))
		else $error("zero length playlist not faulted");
	defer_stream_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(state == ST_IDLE && stream_active) |=> (state == ST_IDLE))
		else $error("playback started while streaming active");
	capacity_full_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(reg_rd && reg_addr == REG_CAPACITY && num_stored == '0) |=> (reg_rdata == DATA_W'(SHARED_DEPTH)))
		else $error("capacity not full with nothing stored");
	burst_step_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(reg_rd && reg_addr == REG_RD_DATA) |=> (rd_ptr == $past(rd_ptr) + ADDR_W'(1)))
		else $error("read pointer did not advance");
	first_start_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(state == ST_LOAD && play && cur_sel == '0) |=> (cur_addr == RAM_BASE))
		else $error("waveform zero not started at memory base");
	self_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(finish && !reg_wr) |=> (!play ##1 state == ST_IDLE))
		else $error("play bit not cleared after playlist end");
	strobe_rate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		dac_strobe |-> ($past(div_cnt) == rate_div($past(sample_rate_select)) - DIV_W'(1)))
		else $error("sample strobe off the selected rate");
endmodule // rwp_player
`default_nettype wire

// ---- tb/rwp_host.sv ----
// host model driving the player's register port
`timescale 1ns/1ps
`default_nettype none
module rwp_host
	import rwp_pkg::*;
(
	// clock
	input  wire logic                       ref_clk,
	// register port
	output logic      [rwp_pkg::ADDR_W-1:0] reg_addr,
	output logic      [rwp_pkg::DATA_W-1:0] reg_wdata,
	output logic                            reg_wr,
	output logic                            reg_rd,
	input  wire logic [rwp_pkg::DATA_W-1:0] reg_rdata
);
	initial begin
		reg_addr  = '0;
		reg_wdata = '0;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
	end

	// idle bus shows inverted values so stale data never looks valid
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr    <= 1'b0;
		reg_addr  <= ~a;
		reg_wdata <= ~d;
	endtask

	// data stands only in the cycle after the strobe
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd   <= 1'b0;
		reg_addr <= ~a;
		@(negedge ref_clk);
		d = reg_rdata;
	endtask

	task automatic mem_wr(input int idx, input logic [DATA_W-1:0] d);
		wr(RAM_BASE + ADDR_W'(idx), d);
	endtask
endmodule // rwp_host
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the playlist player
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_fail++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
	import rwp_pkg::*;
	localparam int DIV = 50;
	logic              ref_clk = 1'b0;
	logic              rst_n = 1'b0;
	logic              stream_active = 1'b0;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata;
	logic              reg_wr;
	logic              reg_rd;
	logic [DATA_W-1:0] reg_rdata;
	logic              stream_grant;
	logic [SMP_W-1:0]  dac_code;
	logic              dac_strobe;
	logic              play_busy;
	int                n_fail = 0;
	int                total_checks = 0;
	int                seed = 24549;
	int                cyc = 0;
	int                k;
	logic [DATA_W-1:0] rv;
	logic [SMP_W-1:0]  words [8];
	logic [ADDR_W-1:0] ea [2] = '{16'h2001, 16'h2004};
	logic [SMP_W-1:0]  got [$];
	logic [SMP_W-1:0]  exp_q [$];
	int                stamp [$];

	always #12.5 ref_clk = ~ref_clk;

	rwp_player #(.DIV_8K(DIV)) i_rwp_player (
		.ref_clk      (ref_clk),
		.rst_n        (rst_n),
		.reg_addr     (reg_addr),
		.reg_wdata    (reg_wdata),
		.reg_wr       (reg_wr),
		.reg_rd       (reg_rd),
		.reg_rdata    (reg_rdata),
		.stream_active(stream_active),
		.stream_grant (stream_grant),
		.dac_code     (dac_code),
		.dac_strobe   (dac_strobe),
		.play_busy    (play_busy)
	);

	rwp_host i_rwp_host (
		.ref_clk  (ref_clk),
		.reg_addr (reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr   (reg_wr),
		.reg_rd   (reg_rd),
		.reg_rdata(reg_rdata)
	);

	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (dac_strobe === 1'b1) begin
			got.push_back(dac_code);
			stamp.push_back(cyc);
		end
	end

	function automatic logic [SMP_W-1:0] comp(input logic [SMP_W-1:0] c);
		return SMP_W'((int'(c) * 7 >> 3) + 508);
	endfunction

	// expected samples of one playlist entry
	function automatic void build(input int sel, input int reps);
		int s;
		int e;
		s = (sel == 0) ? 0 : int'(ea[sel-1]) - 'h2000 + 1;
		e = int'(ea[sel]) - 'h2000;
		repeat (reps) for (int i = s; i <= e; i++) exp_q.push_back(comp(words[i]));
	endfunction

	task automatic results();
		$display("checks=%0d mismatches=%0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// want > 0 waits for that many samples, else for idle
	task automatic wait_for(input int want, input int lim);
		int n;
		n = 0;
		repeat (3) @(negedge ref_clk);
		while ((want > 0 ? got.size() < want : play_busy !== 1'b0) && n < lim) begin
			@(negedge ref_clk);
			n++;
		end
		// the last strobe is caught one edge after busy drops
		repeat (2) @(negedge ref_clk);
		if (n >= lim) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, n, lim);
			results();
		end
	endtask

	initial begin
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		i_rwp_host.rd(REG_CAPACITY, rv);
		`CHK(rv, 16'h2400)
		i_rwp_host.rd(REG_RATE, rv);
		`CHK(rv, 16'h0001)
		i_rwp_host.rd(16'h00FF, rv);
		`CHK(rv, 16'h0000)
		for (int i = 0; i < NUM_WAVES; i++) begin
			i_rwp_host.rd(16'h0030 + 16'(i), rv);
			`CHK(rv, 16'h0001)
			i_rwp_host.wr(16'h0010 + 16'(i), 16'h2100 + 16'(i));
			i_rwp_host.rd(16'h0010 + 16'(i), rv);
			`CHK(rv, 16'h2100 + 16'(i))
		end
		$display("test registers done");
		// upper bits of each word must be dropped by the memory
		for (int i = 0; i < 8; i++) begin
			rv = 16'($random(seed));
			words[i] = rv[SMP_W-1:0];
			i_rwp_host.mem_wr(i, rv);
		end
		i_rwp_host.wr(REG_RD_ADDR, RAM_BASE);
		for (int i = 0; i < 8; i++) begin
			i_rwp_host.rd(REG_RD_DATA, rv);
			`CHK(rv, {4'h0, words[i]})
		end
		i_rwp_host.wr(REG_RD_ADDR, 16'h2005);
		i_rwp_host.rd(REG_RD_DATA, rv);
		`CHK(rv, {4'h0, words[5]})
		$display("test memory done");
		i_rwp_host.wr(16'h0010, ea[0]);
		i_rwp_host.wr(16'h0011, ea[1]);
		i_rwp_host.wr(REG_NSTORED, 16'h0002);
		i_rwp_host.wr(16'h0020, 16'h0001);
		i_rwp_host.wr(16'h0021, 16'h0000);
		i_rwp_host.wr(16'h0030, 16'h0002);
		i_rwp_host.wr(REG_NPLAY, 16'h0002);
		i_rwp_host.wr(REG_RATE, {14'h0, RATE_8K});
		i_rwp_host.rd(REG_CAPACITY, rv);
		`CHK(rv, 16'h2400 - 16'h0005)
		got.delete();
		stamp.delete();
		build(1, 2);
		build(0, 1);
		i_rwp_host.wr(REG_CTRL, 16'h0001);
		wait_for(0, 2000);
		`CHK(got.size(), exp_q.size())
		for (int i = 0; i < exp_q.size() && i < got.size(); i++) `CHK(got[i], exp_q[i])
		`CHK(stamp[1] - stamp[0], DIV)
		i_rwp_host.rd(REG_CTRL, rv);
		`CHK(rv[CTRL_PLAY_BIT], 1'b0)
		$display("test playlist done");
		// empty store, zero length, equal ending addresses
		for (int t = 0; t < 3; t++) begin
			i_rwp_host.wr(REG_NSTORED, (t == 0) ? 16'h0000 : 16'h0002);
			i_rwp_host.wr(REG_NPLAY, (t == 1) ? 16'h0000 : 16'h0002);
			i_rwp_host.wr(16'h0011, (t == 2) ? ea[0] : ea[1]);
			i_rwp_host.wr(REG_CTRL, 16'h0001);
			i_rwp_host.rd(REG_STATUS, rv);
			`CHK(rv[1:0], (t == 0) ? 2'b10 : 2'b01)
			`CHK(play_busy, 1'b0)
			i_rwp_host.wr(REG_STATUS, 16'h0003);
		end
		i_rwp_host.wr(16'h0011, ea[1]);
		i_rwp_host.wr(REG_RATE, {14'h0, RATE_32K});
		$display("test faults done");
		@(posedge ref_clk);
		stream_active <= 1'b1;
		i_rwp_host.wr(REG_CTRL, 16'h0001);
		repeat (3) @(negedge ref_clk);
		`CHK(play_busy, 1'b0)
		`CHK(stream_grant, 1'b0)
		i_rwp_host.rd(REG_STATUS, rv);
		`CHK(rv[STAT_PEND_BIT], 1'b1)
		got.delete();
		stamp.delete();
		@(posedge ref_clk);
		stream_active <= 1'b0;
		wait_for(0, 12000);
		`CHK(got.size(), exp_q.size())
		`CHK(stamp[1] - stamp[0], 1250)
		`CHK(stream_grant, 1'b1)
		$display("test deferral done");
		i_rwp_host.wr(16'h0030, 16'h0000);
		i_rwp_host.wr(REG_NPLAY, 16'h0001);
		i_rwp_host.wr(REG_RATE, {14'h0, RATE_48K});
		got.delete();
		stamp.delete();
		i_rwp_host.wr(REG_CTRL, 16'h0001);
		wait_for(8, 9000);
		`CHK(got[6], comp(words[2]))
		`CHK(stamp[1] - stamp[0], 833)
		i_rwp_host.wr(REG_CTRL, 16'h0000);
		repeat (2) @(negedge ref_clk);
		`CHK(play_busy, 1'b0)
		k = got.size();
		repeat (900) @(posedge ref_clk);
		`CHK(got.size(), k)
		$display("test endless repeat done");
		results();
	end
endmodule // tb
`default_nettype wire
